// >>> design/arb_result_regs.v
// Read-only conversion result register bank with compact addressing
`timescale 1ns/100ps
`include "arb_readout_regs.vh"

module arb_result_regs (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Mode and product variant
    input wire i_compact_mode,
    input wire [1:0] i_variant,
    // Conversion results from the filters
    input wire i_res_valid,
    input wire [2:0] i_res_chan,
    input wire [23:0] i_res_data,
    input wire i_frame_strobe,
    // Host read port
    input wire i_burst_active,
    input wire i_rd_strobe,
    input wire [5:0] i_rd_addr,
    output reg o_rd_valid,
    output reg o_rd_hit,
    output reg [7:0] o_rd_data,
    // Interrupt controller side effect
    output reg o_rdy_clear
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    // Timing of one byte read, counted from the strobe cycle:
    //   cycle 0  strobe and address are decoded, memory read starts
    //   cycle 1  decode and memory word sit side by side in stage 1
    //   cycle 2  answer, hit flag and ready-clear pulse stand here
    // The port never stalls, so strobes may follow one another on
    // every cycle and each one gets exactly one answer.

    // Bank holding the frame the host sees
    reg active_bank;
    // A frame finished while a burst was running
    reg flip_pending;
    // Per bank, per channel: written at least once since reset
    reg [4:0] loaded_bank0;
    reg [4:0] loaded_bank1;
    // A data read has already been seen in this frame
    reg read_seen;

    // Address decode
    wire [4:0] hit_nrm;
    wire [4:0] hit_cmp;
    wire [4:0] present;
    reg [4:0] hit_vec;
    reg [2:0] sel_chan;
    reg [1:0] sel_field;
    reg sel_hit;
    reg sel_loaded;

    // Stage 1 of the read pipeline
    reg p1_valid;
    reg p1_hit;
    reg [2:0] p1_chan;
    reg [1:0] p1_field;
    reg p1_loaded;

    // Memory ports
    wire mem_we;
    wire [3:0] mem_waddr;
    wire [3:0] mem_raddr;
    wire [23:0] mem_rdata;

    // Frame flip and read data selection
    wire flip_now;
    reg [7:0] next_rd_data;
    reg [7:0] tag_byte;
    integer k;

    ////////////////////////////////////////////////////////////////////
    // Per-channel address match in both maps
    // Normal map: each channel owns an aligned block of four bytes,
    // tag first, then high, middle and low result byte.
    // Compact map: each channel owns an aligned pair, high then
    // middle, so a host can fetch the upper bytes of every channel
    // in one short burst. Tag and low bytes have no compact address.

    genvar g;
    generate
        for (g = 0; g < `ARB_NCH; g = g + 1) begin : gen_chan
            localparam integer NRM_BASE = `ARB_NRM_FIRST
                + g * `ARB_NRM_STRIDE;
            localparam integer CMP_BASE = `ARB_CMP_FIRST
                + g * `ARB_CMP_STRIDE;
            // Normal map: four bytes per channel block
            assign hit_nrm[g] = (i_rd_addr[5:2] == NRM_BASE[5:2]);
            // Compact map: high and mid only, two bytes per channel
            assign hit_cmp[g] = (i_rd_addr[5:1] == CMP_BASE[5:1]);
            // Upper three channels absent on the three-channel part
            assign present[g] = (g < 2) ||
                (i_variant != `ARB_VAR_3CH);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Select channel and field from the matched address
    always @* begin
        hit_vec = present & (i_compact_mode ? hit_cmp : hit_nrm);
        sel_hit = |hit_vec;
        sel_chan = 3'h0;
        // The maps never overlap, so at most one match bit is set
        for (k = 0; k < `ARB_NCH; k = k + 1) begin
            if (hit_vec[k]) begin
                sel_chan = k[2:0];
            end
        end
        // Compact addresses can only name high or mid, so tag and
        // low bytes have no address at all in that mode
        if (i_compact_mode) begin
            sel_field = i_rd_addr[0] ? `ARB_FLD_MID : `ARB_FLD_HIGH;
        end else begin
            sel_field = i_rd_addr[1:0];
        end
        // Reads of a never-written entry show the reset value
        if (active_bank) begin
            sel_loaded = loaded_bank1[sel_chan];
        end else begin
            sel_loaded = loaded_bank0[sel_chan];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result memory: new results go to the hidden bank
    // Two banks of eight words: the upper address bit picks the
    // bank, the lower bits the channel. Only five words per bank are
    // used; the rest keep the memory a power of two deep.

    assign mem_we = i_res_valid && (i_res_chan < 3'h5);
    assign mem_waddr = {~active_bank, i_res_chan};
    assign mem_raddr = {active_bank, sel_chan};

    arb_result_mem i_arb_result_mem (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(i_res_data),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Frame flip: never while a burst runs, so a burst sees one frame.
    // The cost is that a late burst may read a frame one step old.
    // Limitation: if two frames end while one burst runs, only the
    // newer one is ever shown; the older results are overwritten in
    // the hidden bank before the host can see them.

    assign flip_now = (i_frame_strobe || flip_pending) &&
        !i_burst_active;

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            active_bank <= 1'b0;
            flip_pending <= 1'b0;
        end else begin
            if (flip_now) begin
                active_bank <= ~active_bank;
                flip_pending <= 1'b0;
            end else if (i_frame_strobe) begin
                flip_pending <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Loaded flags, set as each channel's result is written
    // The memory itself has no reset, so these flags stand in for
    // it: a word not written since reset reads as the reset value.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            loaded_bank0 <= 5'h00;
            loaded_bank1 <= 5'h00;
        end else if (mem_we) begin
            if (active_bank) begin
                loaded_bank0[i_res_chan] <= 1'b1;
            end else begin
                loaded_bank1[i_res_chan] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read pipeline stage 1: decode registered beside the memory read
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            p1_valid <= 1'b0;
            p1_hit <= 1'b0;
            p1_chan <= 3'h0;
            p1_field <= `ARB_FLD_TAG;
            p1_loaded <= 1'b0;
        end else begin
            p1_valid <= i_rd_strobe;
            p1_hit <= i_rd_strobe && sel_hit;
            p1_chan <= sel_chan;
            p1_field <= sel_field;
            p1_loaded <= sel_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Constant tag per channel
    // Tags are fixed by channel, not stored, so they read the same in
    // every frame and straight after reset.
    always @* begin
        case (p1_chan)
            `ARB_CH_I1: tag_byte = `ARB_TAG_I1;
            `ARB_CH_V1: tag_byte = `ARB_TAG_V1;
            `ARB_CH_I2: tag_byte = `ARB_TAG_I2;
            `ARB_CH_V2: tag_byte = `ARB_TAG_V2;
            `ARB_CH_I3: tag_byte = `ARB_TAG_I3;
            default: tag_byte = `ARB_RST_DATA;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Byte selection; the four-channel part returns stored data for
    // current2 and current3, which the host is expected to ignore
    // Refused reads (unmapped address, absent channel, or a tag or
    // low byte in compact mode) leave p1_hit low and answer 0x00.
    always @* begin
        next_rd_data = `ARB_RST_DATA;
        if (p1_hit) begin
            case (p1_field)
                `ARB_FLD_TAG: begin
                    next_rd_data = tag_byte;
                end
                `ARB_FLD_HIGH: begin
                    if (p1_loaded) begin
                        next_rd_data =
                            mem_rdata[`ARB_HIGH_MSB:`ARB_HIGH_LSB];
                    end
                end
                `ARB_FLD_MID: begin
                    if (p1_loaded) begin
                        next_rd_data =
                            mem_rdata[`ARB_MID_MSB:`ARB_MID_LSB];
                    end
                end
                `ARB_FLD_LOW: begin
                    if (p1_loaded) begin
                        next_rd_data =
                            mem_rdata[`ARB_LOW_MSB:`ARB_LOW_LSB];
                    end
                end
                default: begin
                    next_rd_data = `ARB_RST_DATA;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read answer registers
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rd_valid <= 1'b0;
            o_rd_hit <= 1'b0;
            o_rd_data <= `ARB_RST_DATA;
        end else begin
            o_rd_valid <= p1_valid;
            o_rd_hit <= p1_hit;
            o_rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ready-clear: one pulse for the first data read of each frame.
    // A flip clears the seen flag and wins over a read in that cycle,
    // since the read in flight belongs to the frame just retired.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            read_seen <= 1'b0;
            o_rdy_clear <= 1'b0;
        end else begin
            o_rdy_clear <= p1_hit && !read_seen;
            if (flip_now) begin
                read_seen <= 1'b0;
            end else if (p1_hit) begin
                read_seen <= 1'b1;
            end
        end
    end

endmodule

// >>> design/arb_readout_regs.vh
// Constants for the conversion result readout register bank
`ifndef ARB_READOUT_REGS_VH
`define ARB_READOUT_REGS_VH

// Geometry
`define ARB_NCH 5
`define ARB_ADDR_W 6
`define ARB_RES_W 24

// Normal map: channel block base and stride (tag, high, mid, low)
`define ARB_NRM_FIRST 6'h04
`define ARB_NRM_STRIDE 6'h04

// Compact map: high and mid bytes packed two per channel
`define ARB_CMP_FIRST 6'h02
`define ARB_CMP_STRIDE 6'h02

// Field codes inside a channel block (low address bits, normal map)
`define ARB_FLD_TAG 2'h0
`define ARB_FLD_HIGH 2'h1
`define ARB_FLD_MID 2'h2
`define ARB_FLD_LOW 2'h3

// Result byte positions inside the 24-bit result
`define ARB_HIGH_MSB 23
`define ARB_HIGH_LSB 16
`define ARB_MID_MSB 15
`define ARB_MID_LSB 8
`define ARB_LOW_MSB 7
`define ARB_LOW_LSB 0

// Channel indices
`define ARB_CH_I1 3'h0
`define ARB_CH_V1 3'h1
`define ARB_CH_I2 3'h2
`define ARB_CH_V2 3'h3
`define ARB_CH_I3 3'h4

// Constant channel tags
`define ARB_TAG_I1 8'h02
`define ARB_TAG_V1 8'h03
`define ARB_TAG_I2 8'h04
`define ARB_TAG_V2 8'h05
`define ARB_TAG_I3 8'h06

// Product variant codes
`define ARB_VAR_3CH 2'h0
`define ARB_VAR_4CH 2'h1
`define ARB_VAR_7CH 2'h2

// Reset value of every result byte and of the read data output
`define ARB_RST_DATA 8'h00

`endif

// >>> design/arb_result_mem.v
// Two-bank result memory, one write port, registered read port
`timescale 1ns/100ps

module arb_result_mem (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Write port
    input wire i_we,
    input wire [3:0] i_waddr,
    input wire [23:0] i_wdata,
    // Read port
    input wire [3:0] i_raddr,
    output reg [23:0] o_rdata
);

    reg [23:0] mem [0:15];

    ////////////////////////////////////////////////////////////////////
    // Storage has no reset; the caller masks entries never written
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data leaves through a register
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 24'h000000;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// >>> sim/arb_result_regs_monitor.sv
// Port assertions for the result readout register bank
`timescale 1ns/100ps
module arb_result_regs_monitor (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Mode and variant
    input wire i_compact_mode,
    input wire [1:0] i_variant,
    // Result load
    input wire i_res_valid,
    input wire [2:0] i_res_chan,
    input wire [23:0] i_res_data,
    input wire i_frame_strobe,
    // Host read port
    input wire i_burst_active,
    input wire i_rd_strobe,
    input wire [5:0] i_rd_addr,
    input wire o_rd_valid,
    input wire o_rd_hit,
    input wire [7:0] o_rd_data,
    input wire o_rdy_clear
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Reads decoded with the normal map, and larger parts only
    wire nrm = i_rd_strobe && !i_compact_mode;
    wire big = i_variant != 2'h0;
    chk_answer_late: assert property (
        i_rd_strobe |-> ##2 o_rd_valid) else $error("answer late");
    chk_answer_extra: assert property (
        !i_rd_strobe |-> ##2 !o_rd_valid) else $error("answer unasked");
    chk_tag_cur1: assert property (
        nrm && i_rd_addr == 6'h04 |-> ##2 o_rd_hit && o_rd_data == 8'h02)
        else $error("current1 tag wrong");
    chk_tag_volt1: assert property (
        nrm && i_rd_addr == 6'h08 |-> ##2 o_rd_hit && o_rd_data == 8'h03)
        else $error("voltage1 tag wrong");
    chk_tag_cur2: assert property (
        nrm && big && i_rd_addr == 6'h0c |-> ##2 o_rd_data == 8'h04)
        else $error("current2 tag wrong");
    chk_tag_volt2: assert property (
        nrm && big && i_rd_addr == 6'h10 |-> ##2 o_rd_data == 8'h05)
        else $error("voltage2 tag wrong");
    chk_tag_cur3: assert property (
        nrm && big && i_rd_addr == 6'h14 |-> ##2 o_rd_data == 8'h06)
        else $error("current3 tag wrong");
    chk_compact_hide: assert property (
        i_rd_strobe && i_compact_mode && i_rd_addr >= 6'h0c
        |-> ##2 !o_rd_hit) else $error("compact hidden byte read");
    chk_compact_first: assert property (
        i_rd_strobe && i_compact_mode && i_rd_addr == 6'h02
        |-> ##2 o_rd_hit) else $error("compact current1 missing");
    chk_absent_chan: assert property (
        nrm && !big && i_rd_addr inside {[6'h0c:6'h17]} |-> ##2 !o_rd_hit)
        else $error("absent channel answered");
    chk_miss_zero: assert property (
        o_rd_valid && !o_rd_hit |-> o_rd_data == 8'h00)
        else $error("refused read not zero");
    chk_clear_hit: assert property (
        o_rdy_clear |-> o_rd_valid && o_rd_hit) else $error("stray clear");
endmodule
bind arb_result_regs arb_result_regs_monitor i_arb_result_regs_monitor (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_compact_mode(i_compact_mode),
    .i_variant(i_variant), .i_res_valid(i_res_valid),
    .i_res_chan(i_res_chan), .i_res_data(i_res_data),
    .i_frame_strobe(i_frame_strobe), .i_burst_active(i_burst_active),
    .i_rd_strobe(i_rd_strobe), .i_rd_addr(i_rd_addr),
    .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit), .o_rd_data(o_rd_data),
    .o_rdy_clear(o_rdy_clear)
);

// >>> sim/arb_host_model.sv
// Host model turning bench requests into one-cycle byte read strobes
`timescale 1ns/100ps
module arb_host_model (
    // Clock
    input wire i_clk,
    // Requests from the bench
    input wire i_go,
    input wire [5:0] i_addr,
    input wire i_burst,
    // Read port towards the bank
    output reg o_rd_strobe = 1'b0,
    output reg [5:0] o_rd_addr = 6'h00,
    output reg o_burst_active = 1'b0
);
    // Idle address toggles so a stale value never looks like a request
    always @(posedge i_clk) begin
        o_rd_strobe <= i_go;
        o_rd_addr <= i_go ? i_addr : ~o_rd_addr;
        o_burst_active <= i_burst;
    end
endmodule

// >>> sim/test_adc_result_readout_regs.sv
// Self-checking bench for the result readout register bank
`timescale 1ns/100ps
module test_adc_result_readout_regs;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg compact = 1'b0;
    reg [1:0] variant = 2'h2;
    reg res_valid = 1'b0;
    reg [2:0] res_chan = 3'h0;
    reg [23:0] res_data = 24'h000000;
    reg frame = 1'b0;
    reg go = 1'b0;
    reg [5:0] addr = 6'h00;
    reg burst = 1'b0;
    wire rd_strobe;
    wire [5:0] rd_addr;
    wire burst_active;
    wire valid;
    wire hit;
    wire clr;
    wire [7:0] data;
    reg [23:0] vis [0:4];
    reg [23:0] hid [0:4];
    reg seen = 1'b0;
    reg [31:0] seed = 32'd91746;
    reg [10:0] notes [$];
    integer miscompares = 0;
    integer num_checks = 0;
    integer i;
    integer j;

    always #4 clk = ~clk;

    arb_host_model i_arb_host_model (
        .i_clk(clk), .i_go(go), .i_addr(addr), .i_burst(burst),
        .o_rd_strobe(rd_strobe), .o_rd_addr(rd_addr),
        .o_burst_active(burst_active)
    );
    arb_result_regs i_arb_result_regs (
        .i_clk(clk), .i_resetn(resetn), .i_compact_mode(compact),
        .i_variant(variant), .i_res_valid(res_valid),
        .i_res_chan(res_chan), .i_res_data(res_data),
        .i_frame_strobe(frame), .i_burst_active(burst_active),
        .i_rd_strobe(rd_strobe), .i_rd_addr(rd_addr), .o_rd_valid(valid),
        .o_rd_hit(hit), .o_rd_data(data), .o_rdy_clear(clr)
    );

    function [31:0] rnd(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            rnd = x ^ (x << 5);
        end
    endfunction

    // Expected {hit, data} of one address under the current map
    function [8:0] want(input [5:0] a);
        reg [2:0] c;
        begin
            c = 3'h0;
            want = 9'h000;
            if (!compact && a >= 6'h04 && a < 6'h18) begin
                c = 3'((a - 6'h04) >> 2);
                case (a[1:0])
                    2'h0: want = {1'b1, 8'h02 + 8'(c)};
                    2'h1: want = {1'b1, vis[c][23:16]};
                    2'h2: want = {1'b1, vis[c][15:8]};
                    default: want = {1'b1, vis[c][7:0]};
                endcase
            end else if (compact && a >= 6'h02 && a < 6'h0c) begin
                c = 3'((a - 6'h02) >> 1);
                want = {1'b1, a[0] ? vis[c][15:8] : vis[c][23:16]};
            end
            if (variant == 2'h0 && c >= 3'h2)
                want = 9'h000;
        end
    endfunction

    // One byte request; note is {ignore, hit, clear, data}
    task rd(input [5:0] a, input ign);
        reg [8:0] e;
        begin
            e = want(a);
            notes.push_back({ign, e[8], e[8] & !seen, e[7:0]});
            seen = seen | e[8];
            go <= 1'b1;
            addr <= a;
            @(posedge clk);
        end
    endtask

    task idle(input integer n);
        begin
            go <= 1'b0;
            repeat (n) @(posedge clk);
        end
    endtask

    task sweep;
        begin
            for (i = 0; i < 32; i = i + 1)
                rd(6'(i), 1'b0);
            idle(4);
        end
    endtask

    // Shown bank takes the hidden one; a new frame clears seen reads
    task flip;
        begin
            for (j = 0; j < 5; j = j + 1)
                vis[j] = hid[j];
            seen = 1'b0;
        end
    endtask

    // All channels back to back, then one out-of-range channel
    task load;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                seed = rnd(seed);
                if (i < 5)
                    hid[i] = seed[23:0];
                res_valid <= 1'b1;
                res_chan <= 3'(i);
                res_data <= seed[23:0];
                @(posedge clk);
            end
            res_valid <= 1'b0;
            frame <= 1'b1;
            @(posedge clk);
            frame <= 1'b0;
            if (!burst)
                flip;
        end
    endtask

    task cmp_rd(input [10:0] n);
        begin
            if (!n[10]) begin
                num_checks = num_checks + 1;
                if ({hit, clr, data} !== n[9:0]) begin
                    miscompares = miscompares + 1;
                    $display("Error %0t: read %h", $time, {hit, clr, data});
                end
            end
        end
    endtask

    // Each answer takes the oldest note
    always @(posedge clk) begin
        if (valid === 1'b1) begin
            if (notes.size() == 0) begin
                miscompares = miscompares + 1;
                $display("Error %0t: unasked answer", $time);
            end else
                cmp_rd(notes.pop_front());
        end
    end

    task give_verdict;
        begin
            if (notes.size() != 0) begin
                miscompares = miscompares + 1;
                $display("Error %0t: answers missing", $time);
            end
            if (miscompares == 0 && num_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        $display("Error %0t: run too long", $time);
        give_verdict;
    end

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        load;
        sweep;
        compact <= 1'b1;
        idle(1);
        sweep;
        compact <= 1'b0;
        variant <= 2'h0;
        idle(1);
        sweep;
        variant <= 2'h1;
        idle(1);
        rd(6'h0c, 1'b1);
        rd(6'h15, 1'b1);
        idle(1);
        variant <= 2'h2;
        burst <= 1'b1;
        idle(4);
        rd(6'h05, 1'b0);
        idle(1);
        load;
        rd(6'h06, 1'b0);
        rd(6'h07, 1'b0);
        idle(4);
        burst <= 1'b0;
        idle(2);
        flip;
        rd(6'h05, 1'b0);
        idle(4);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        // Reset empties both banks and the seen flag
        for (j = 0; j < 5; j = j + 1)
            vis[j] = 24'h000000;
        seen = 1'b0;
        rd(6'h06, 1'b0);
        idle(1);
        load;
        rd(6'h09, 1'b0);
        rd(6'h13, 1'b0);
        idle(4);
        give_verdict;
    end
endmodule
